// >>> logic/mct_device.sv
// Device end: monitor conditioning, clocks, timers, readout
`timescale 1ns/1ps
// ==================================================================
// What this block does
// - Window is lower compare and not upper
// - Primary output selects upper compare or window
// - Window mode needs upper threshold above lower
// - Secondary output always follows lower compare
// - Filter on: 64 us delay, glitches rejected
// - Filter off: 16 us delay
// - Outputs always resynchronised to logic clock
// - Comparator status readable by the host
// - Mux picks any channel, attenuate or not
// - Host measures any time; result latched
// - Attenuated code times three, 12-bit readout
// - Readout split 8 high, 4 low; 2 mV
// - Divide 8 MHz source by 32
// - Comparators registered on logic clock
// - Master clock drives sampling and filters
// - Switches pick standalone, master or slave
// - One board is master, rest slaves
// - Export switch drives logic clock pin
// - Four timers, 128 steps, 32 us-1.96 s
module mct_device #(
  parameter int CLK_HZ = mct_pkg::REF_CLK_HZ // Reference clock rate
) (
  input  wire logic                         ref_clk,                 // Reference clock
  input  wire logic                         rstn,                    // Async reset, low
  input  wire logic [mct_pkg::NUM_CH-1:0]   upper_threshold_compare, // Raw upper results
  input  wire logic [mct_pkg::NUM_CH-1:0]   lower_threshold_compare, // Raw lower results
  input  wire logic                         mclk_in,                 // Clock pin level
  output logic                              mclk_out,                // Clock pin drive
  output logic                              mclk_oe,                 // Clock pin enable
  output logic                              logic_clock_out_pin,     // Logic clock drive
  output logic                              logic_clock_oe,          // Logic clock enable
  output logic [mct_pkg::CH_W-1:0]          adc_mux_sel,             // Converter mux
  output logic                              adc_atten_div3,          // Attenuator setting
  output logic                              adc_start,               // Conversion pulse
  input  wire logic                         adc_done,                // Conversion ready
  input  wire logic [mct_pkg::ADC_W-1:0]    adc_code,                // Converter code
  mct_link_if.dev                           link                     // Host side
);
  localparam int MDIV = CLK_HZ / mct_pkg::MCLK_HZ;
  localparam logic [2:0] MDIV_LAST = 3'(MDIV - 1);
  localparam logic [2:0] MDIV_HALF = 3'(MDIV / 2);
  localparam logic [mct_pkg::FILT_CNT_W-1:0] F_LONG =
    mct_pkg::FILT_CNT_W'(mct_pkg::FILT_LONG_TICKS - 1);
  localparam logic [mct_pkg::FILT_CNT_W-1:0] F_SHORT =
    mct_pkg::FILT_CNT_W'(mct_pkg::FILT_SHORT_TICKS - 1);

  // Slave edge detection needs at least four reference cycles per master cycle
  if (CLK_HZ % mct_pkg::MCLK_HZ != 0 || MDIV < 4 || MDIV > 8) begin : g_bad_clk
    $error("CLK_HZ must be 4 to 8 master clocks");
  end

  // ==================================================================
  // Master clock source and pin
  logic [2:0] mdiv_cnt, next_mdiv_cnt;
  logic       pin_s1, pin_s2, pin_s3, next_mclk_out;
  logic       mtick, itick, etick;
  logic [mct_pkg::LDIV_W-1:0] pre, next_pre;
  logic       ltick, next_lclk;

  // Internal 8 MHz ticks, and rising edges of the pin when slaved
  always_comb begin
    itick = (mdiv_cnt == MDIV_LAST);
    next_mdiv_cnt = itick ? 3'h0 : mdiv_cnt + 3'h1;
    next_mclk_out = (next_mdiv_cnt < MDIV_HALF);
    etick = pin_s2 & ~pin_s3;
    mtick = link.sw_int_clk ? itick : etick;
    ltick = mtick && (pre == {mct_pkg::LDIV_W{1'b1}});
    next_pre = mtick ? pre + 5'h01 : pre;
    next_lclk = pre[mct_pkg::LDIV_W-1];
  end

  // Pin drives only in master mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mdiv_cnt <= 3'h0;
      mclk_out <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pre <= 5'h00;
      logic_clock_out_pin <= 1'b0;
    end else begin
      mdiv_cnt <= next_mdiv_cnt;
      mclk_out <= next_mclk_out;
      pin_s1 <= mclk_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pre <= next_pre;
      logic_clock_out_pin <= next_lclk;
    end
  end

  assign mclk_oe        = link.sw_int_clk & link.sw_pin_link;
  assign logic_clock_oe = link.sw_export;
  assign link.logic_tick = ltick;

  // ==================================================================
  // Per-channel conditioning
  for (genvar i = 0; i < mct_pkg::NUM_CH; i++) begin : g_ch
    logic [1:0] sy1, sy2, filt, next_filt;
    logic [1:0][mct_pkg::FILT_CNT_W-1:0] cnt, next_cnt;
    logic [mct_pkg::FILT_CNT_W-1:0] lim;
    logic a_q, b_q, next_a, next_b, win;

    // Bit 0 upper, bit 1 lower; a change must hold for the whole delay
    always_comb begin
      lim = link.filt_en[i] ? F_LONG : F_SHORT;
      next_filt = filt;
      next_cnt  = cnt;
      for (int k = 0; k < 2; k++) begin
        if (mtick) begin
          if (sy2[k] == filt[k]) begin
            next_cnt[k] = '0;
          end else if (cnt[k] == lim) begin
            next_filt[k] = sy2[k];
            next_cnt[k]  = '0;
          end else begin
            next_cnt[k] = cnt[k] + 10'h001;
          end
        end
      end
      win    = filt[1] & ~filt[0];
      next_a = a_q;
      next_b = b_q;
      if (ltick) begin
        next_a = link.window_mode[i] ? win : filt[0];
        next_b = filt[1];
      end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        sy1  <= 2'h0;
        sy2  <= 2'h0;
        filt <= 2'h0;
        cnt  <= '0;
        a_q  <= 1'b0;
        b_q  <= 1'b0;
      end else begin
        sy1  <= {lower_threshold_compare[i], upper_threshold_compare[i]};
        sy2  <= sy1;
        filt <= next_filt;
        cnt  <= next_cnt;
        a_q  <= next_a;
        b_q  <= next_b;
      end
    end

    assign link.mon_a[i] = a_q;
    assign link.mon_b[i] = b_q;
  end

  // ==================================================================
  // Programmable timers
  for (genvar t = 0; t < mct_pkg::NUM_TMR; t++) begin : g_tmr
    logic [mct_pkg::TMR_CNT_W-1:0]  cnt, next_cnt, limit;
    logic [mct_pkg::TMR_PROD_W-1:0] prod;
    logic done, next_done;

    // Quadratic curve: fine steps short, coarse steps long
    always_comb begin
      prod = 22'(link.tmr_sel[t]) * 22'(link.tmr_sel[t]) * 22'(mct_pkg::TMR_CURVE_MUL);
      limit = mct_pkg::TMR_CNT_W'(mct_pkg::TMR_MIN_TICKS)
        + mct_pkg::TMR_CNT_W'(prod >> mct_pkg::TMR_CURVE_SHIFT);
      next_cnt = cnt;
      next_done = done;
      if (!link.tmr_start[t]) begin
        next_cnt = '0;
        next_done = 1'b0;
      end else if (ltick && !done) begin
        if (cnt == limit - mct_pkg::TMR_CNT_W'(1)) begin
          next_done = 1'b1;
        end else begin
          next_cnt = cnt + mct_pkg::TMR_CNT_W'(1);
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        cnt  <= '0;
        done <= 1'b0;
      end else begin
        cnt  <= next_cnt;
        done <= next_done;
      end
    end

    assign link.tmr_done[t] = done;
  end

  // ==================================================================
  // Measurement sequencing and readout formatting
  typedef enum logic [1:0] {MCT_M_IDLE, MCT_M_CONV, MCT_M_DROP} mct_meas_t;
  mct_meas_t state, next_state;
  logic [mct_pkg::RES_W-1:0] res, next_res;
  logic [mct_pkg::CH_W-1:0]  sel, next_sel;
  logic atten, next_atten, next_start, next_done;

  // Request held until result is back; DROP waits for its release
  always_comb begin
    next_state = state;
    next_res   = res;
    next_sel   = sel;
    next_atten = atten;
    next_start = 1'b0;
    next_done  = 1'b0;
    case (state)
      MCT_M_IDLE: begin
        if (link.meas_req) begin
          next_sel   = link.meas_chan;
          next_atten = link.meas_atten;
          if (link.meas_chan < 4'(mct_pkg::NUM_CH)) begin
            next_start = 1'b1;
            next_state = MCT_M_CONV;
          end else begin
            next_res   = '0; // Nonexistent channel reads zero
            next_done  = 1'b1;
            next_state = MCT_M_DROP;
          end
        end
      end
      MCT_M_CONV: begin
        if (adc_done) begin
          next_res = atten ? 12'(adc_code) * 12'(mct_pkg::ATTEN_GAIN)
                           : 12'(adc_code);
          next_done  = 1'b1;
          next_state = MCT_M_DROP;
        end
      end
      default: begin
        if (!link.meas_req) begin
          next_state = MCT_M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= MCT_M_IDLE;
      res <= '0;
      sel <= '0;
      atten <= 1'b0;
      adc_start <= 1'b0;
      link.meas_done <= 1'b0;
    end else begin
      state <= next_state;
      res <= next_res;
      sel <= next_sel;
      atten <= next_atten;
      adc_start <= next_start;
      link.meas_done <= next_done;
    end
  end

  assign adc_mux_sel    = sel;
  assign adc_atten_div3 = atten;
  assign link.res_high  = res[mct_pkg::RES_W-1:mct_pkg::RES_LO_W];
  assign link.res_low   = res[mct_pkg::RES_LO_W-1:0];
endmodule

// >>> logic/mct_pkg.sv
// Constants and types for the monitor, clock and timer block
package mct_pkg;
  // ==================================================================
  // Sizes
  localparam int NUM_CH   = 12; // Monitor channels
  localparam int CH_W     = 4;  // Channel select width
  localparam int NUM_TMR  = 4;  // Programmable timers
  localparam int TSEL_W   = 7;  // Timer step select, 128 steps
  localparam int ADC_W    = 10; // Raw converter code
  localparam int RES_W    = 12; // Stored readout
  localparam int RES_HI_W = 8;  // Readout high part
  localparam int RES_LO_W = 4;  // Readout low part
  localparam int ATTEN_GAIN = 3; // Readout scale when dividing by three
  localparam int MV_PER_LSB = 2; // Readout weight in millivolts
  localparam int MV_W       = 14;
  // ==================================================================
  // Clocks
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int MCLK_HZ    = 8_000_000;
  localparam int MCLK_PER_US = MCLK_HZ / 1_000_000;
  localparam int LOGIC_DIV  = 32; // Master ticks per logic tick
  localparam int LDIV_W     = 5;
  // ==================================================================
  // Filter delays, counted in master clock ticks
  localparam int FILT_LONG_US     = 64;
  localparam int FILT_SHORT_US    = 16;
  localparam int FILT_LONG_TICKS  = FILT_LONG_US * MCLK_PER_US;
  localparam int FILT_SHORT_TICKS = FILT_SHORT_US * MCLK_PER_US;
  localparam int FILT_CNT_W       = 10;
  // ==================================================================
  // Timers, counted in logic clock ticks
  localparam int TMR_MIN_US     = 32;
  localparam int TMR_MIN_TICKS  = TMR_MIN_US * MCLK_PER_US / LOGIC_DIV;
  localparam int TMR_CURVE_MUL  = 243; // Top step lands near 1.96 s
  localparam int TMR_CURVE_SHIFT = 3;
  localparam int TMR_PROD_W     = 22;
  localparam int TMR_CNT_W      = 19;
  // ==================================================================
  // Board clock roles
  typedef enum logic [1:0] {MCT_STANDALONE, MCT_MASTER, MCT_SLAVE} mct_clk_mode_t;
endpackage

// >>> logic/mct_link_if.sv
// Link between the device end and the host end
`timescale 1ns/1ps
interface mct_link_if;
  logic [mct_pkg::NUM_CH-1:0]   mon_a;       // Primary outputs
  logic [mct_pkg::NUM_CH-1:0]   mon_b;       // Secondary outputs
  logic                         logic_tick;  // One cycle per logic clock
  logic [mct_pkg::NUM_CH-1:0]   window_mode; // Primary shows window
  logic [mct_pkg::NUM_CH-1:0]   filt_en;     // Long noise filter
  logic                         sw_int_clk;  // Internal clock switch
  logic                         sw_pin_link; // Clock pin link switch
  logic                         sw_export;   // Logic clock export
  logic                         meas_req;    // Measurement request
  logic [mct_pkg::CH_W-1:0]     meas_chan;   // Channel to measure
  logic                         meas_atten;  // Divide by three
  logic                         meas_done;   // Result latched pulse
  logic [mct_pkg::RES_HI_W-1:0] res_high;    // Readout high part
  logic [mct_pkg::RES_LO_W-1:0] res_low;     // Readout low part
  logic [mct_pkg::NUM_TMR-1:0]  tmr_start;   // Timer run controls
  logic [mct_pkg::NUM_TMR-1:0]  tmr_done;    // Timer timeout flags
  logic [mct_pkg::NUM_TMR-1:0][mct_pkg::TSEL_W-1:0] tmr_sel; // Timer step selects

  modport dev (
    output mon_a, mon_b, logic_tick, meas_done, res_high, res_low, tmr_done,
    input  window_mode, filt_en, sw_int_clk, sw_pin_link, sw_export,
    input  meas_req, meas_chan, meas_atten, tmr_start, tmr_sel
  );
  modport host (
    input  mon_a, mon_b, logic_tick, meas_done, res_high, res_low, tmr_done,
    output window_mode, filt_en, sw_int_clk, sw_pin_link, sw_export,
    output meas_req, meas_chan, meas_atten, tmr_start, tmr_sel
  );
endinterface

// >>> logic/mct_host.sv
// Host end: configuration, measurement requests, status
`timescale 1ns/1ps
module mct_host (
  input  wire logic                          ref_clk,       // Reference clock
  input  wire logic                          rstn,          // Async reset, low
  input  wire mct_pkg::mct_clk_mode_t        clk_mode,      // Board clock role
  input  wire logic                          export_lclk,   // Export logic clock
  input  wire logic [mct_pkg::NUM_CH-1:0]    window_req,    // Want window mode
  input  wire logic [mct_pkg::NUM_CH-1:0]    thr_ordered,   // Upper above lower
  input  wire logic [mct_pkg::NUM_CH-1:0]    filter_req,    // Want long filter
  input  wire logic                          cmd_go,        // Start measurement
  input  wire logic [mct_pkg::CH_W-1:0]      cmd_chan,      // Channel to measure
  input  wire logic                          cmd_atten,     // Use divide by three
  output logic                               cmd_busy,      // Request in flight
  output logic                               res_valid,     // New result pulse
  output logic [mct_pkg::RES_W-1:0]          res_code,      // Joined readout
  output logic [mct_pkg::MV_W-1:0]           res_mv,        // Voltage in mV
  output logic [mct_pkg::NUM_CH-1:0]         status_a,      // Primary status
  output logic [mct_pkg::NUM_CH-1:0]         status_b,      // Secondary status
  input  wire logic [mct_pkg::NUM_TMR-1:0]   tmr_run,       // Timer run requests
  input  wire logic [mct_pkg::NUM_TMR-1:0][mct_pkg::TSEL_W-1:0] tmr_step, // Timer steps
  output logic [mct_pkg::NUM_TMR-1:0]        tmr_expired,   // Timer flags
  mct_link_if.host                           link           // Device side
);
  typedef enum logic {MCT_H_IDLE, MCT_H_WAIT} mct_host_t;
  mct_host_t state, next_state;
  logic [mct_pkg::RES_W-1:0] next_code;
  logic [mct_pkg::MV_W-1:0]  next_mv;
  logic req, next_req, next_valid;
  logic [mct_pkg::CH_W-1:0] chan, next_chan;
  logic atten, next_atten;

  // ==================================================================
  // Hold the request until the device reports done
  always_comb begin
    next_state = state;
    next_req   = req;
    next_chan  = chan;
    next_atten = atten;
    next_code  = res_code;
    next_mv    = res_mv;
    next_valid = 1'b0;
    case (state)
      MCT_H_IDLE: begin
        if (cmd_go) begin
          next_req   = 1'b1;
          next_chan  = cmd_chan;
          next_atten = cmd_atten;
          next_state = MCT_H_WAIT;
        end
      end
      default: begin
        if (link.meas_done) begin
          next_req   = 1'b0;
          next_code  = {link.res_high, link.res_low};
          next_mv    = 14'(next_code) * 14'(mct_pkg::MV_PER_LSB);
          next_valid = 1'b1;
          next_state = MCT_H_IDLE;
        end
      end
    endcase
  end

  // Config is registered so the device never sees glitches
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= MCT_H_IDLE;
      req <= 1'b0;
      chan <= '0;
      atten <= 1'b0;
      res_code <= '0;
      res_mv <= '0;
      res_valid <= 1'b0;
      status_a <= '0;
      status_b <= '0;
      tmr_expired <= '0;
      link.window_mode <= '0;
      link.filt_en <= '0;
      link.sw_int_clk <= 1'b1;
      link.sw_pin_link <= 1'b0;
      link.sw_export <= 1'b0;
      link.tmr_start <= '0;
      link.tmr_sel <= '0;
    end else begin
      state <= next_state;
      req <= next_req;
      chan <= next_chan;
      atten <= next_atten;
      res_code <= next_code;
      res_mv <= next_mv;
      res_valid <= next_valid;
      status_a <= link.mon_a;
      status_b <= link.mon_b;
      tmr_expired <= link.tmr_done;
      link.window_mode <= window_req & thr_ordered;
      link.filt_en <= filter_req;
      // Board role maps to switch pair; only one board should pick master
      link.sw_int_clk <= (clk_mode != mct_pkg::MCT_SLAVE);
      link.sw_pin_link <= (clk_mode != mct_pkg::MCT_STANDALONE);
      link.sw_export <= export_lclk;
      link.tmr_start <= tmr_run;
      link.tmr_sel <= tmr_step;
    end
  end

  assign cmd_busy        = req;
  assign link.meas_req   = req;
  assign link.meas_chan  = chan;
  assign link.meas_atten = atten;
endmodule

// >>> tb/mct_link_properties.sv
// Concurrent checks on the device-host link
`timescale 1ns/1ps
module mct_link_properties (
  input wire logic                         ref_clk,     // Reference clock
  input wire logic                         rstn,        // Async reset, low
  input wire logic [mct_pkg::NUM_CH-1:0]   mon_a,       // Primary outputs
  input wire logic [mct_pkg::NUM_CH-1:0]   mon_b,       // Secondary outputs
  input wire logic                         logic_tick,  // Logic clock pulse
  input wire logic [mct_pkg::NUM_CH-1:0]   window_mode, // Window select
  input wire logic                         sw_int_clk,  // Internal clock switch
  input wire logic                         meas_req,    // Measurement request
  input wire logic                         meas_done,   // Result latched
  input wire logic [mct_pkg::RES_HI_W-1:0] res_high,    // Readout high part
  input wire logic [mct_pkg::RES_LO_W-1:0] res_low,     // Readout low part
  input wire logic [mct_pkg::NUM_TMR-1:0]  tmr_start,   // Timer run
  input wire logic [mct_pkg::NUM_TMR-1:0]  tmr_done     // Timer flags
);
  // ==================================================================
  // Helper logic
  logic [7:0] gap, next_gap;
  logic       seen, next_seen;
  // Cycles since the last tick; the first gap after reset is not judged
  always_comb begin
    next_gap  = logic_tick ? 8'h00 : gap + 8'h01;
    next_seen = seen | logic_tick;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap  <= 8'h00;
      seen <= 1'b0;
    end else begin
      gap  <= next_gap;
      seen <= next_seen;
    end
  end
  // ==================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence req_start;
    $rose(meas_req);
  endsequence
  // The request must fall one cycle after the result lands
  sequence done_then_drop;
    meas_req ##1 (!meas_done && !meas_req);
  endsequence
  mon_hold_a: assert property (!$past(logic_tick) |-> $stable(mon_a) && $stable(mon_b))
    else $error("monitor moved off tick");
  window_imp_a: assert property ($past(logic_tick) |-> (mon_a & $past(window_mode) & ~mon_b) == '0)
    else $error("window high, lower low");
  tick_gap_a: assert property (logic_tick && seen && sw_int_clk |-> gap == 8'h9F)
    else $error("logic tick spacing wrong");
  meas_answer_a: assert property (req_start |-> ##[1:40] meas_done)
    else $error("measurement not answered");
  done_pulse_a: assert property (meas_done |-> done_then_drop)
    else $error("done pulse or drop wrong");
  res_hold_a: assert property ($changed({res_high, res_low}) |-> meas_done)
    else $error("readout moved alone");
  tmr_clear_a: assert property ((tmr_done & ~$past(tmr_start)) == '0)
    else $error("timer flag not cleared");
  tmr_rise_a: assert property ((|(tmr_done & ~$past(tmr_done))) |-> $past(logic_tick))
    else $error("timer flag off tick");
endmodule

// >>> tb/monitor_conditioning_clock_timers_bench.sv
// Bench joining both ends of the monitor link, with a stand-in converter
`timescale 1ns/1ps
module monitor_conditioning_clock_timers_bench;
  typedef struct packed {
    logic [3:0] chan; logic atten; logic [9:0] code; logic [2:0] dly; logic [11:0] exp;
  } mct_row_t;
  // ==================================================================
  // Signals
  logic            ref_clk, rstn, ext_mclk, mclk_in, mclk_out, mclk_oe, adc_start;
  logic            logic_clock_out_pin, logic_clock_oe, adc_atten_div3, adc_done;
  logic            export_lclk, cmd_go, cmd_atten, cmd_busy, res_valid, seen_att, started;
  logic [11:0]     upper_threshold_compare, lower_threshold_compare, window_req;
  logic [11:0]     thr_ordered, filter_req, res_code, status_a, status_b;
  logic [3:0]      adc_mux_sel, cmd_chan, seen_sel, tmr_run, tmr_expired;
  logic [9:0]      adc_code, cur_code;
  logic [13:0]     res_mv;
  logic [2:0]      cur_dly, adc_wait;
  logic [3:0][6:0] tmr_step;
  int              n_mismatch, cmp_count, cycles;
  int              stp [4] = '{0, 1, 2, 1};
  mct_pkg::mct_clk_mode_t clk_mode;
  mct_row_t rows [6] = '{
    '{4'h0, 1'b0, 10'h3FF, 3'h1, 12'h3FF}, '{4'hB, 1'b1, 10'h3FF, 3'h4, 12'hBFD},
    '{4'h5, 1'b1, 10'h155, 3'h2, 12'h3FF}, '{4'h3, 1'b0, 10'h000, 3'h7, 12'h000},
    '{4'h9, 1'b1, 10'h001, 3'h3, 12'h003}, '{4'hF, 1'b1, 10'h200, 3'h1, 12'h000}};
  // Another board's master feeds the pin while ours is off
  assign mclk_in = mclk_oe ? mclk_out : ext_mclk;
  mct_link_if link ();
  mct_device u_mct_device (.ref_clk, .rstn, .upper_threshold_compare, .lower_threshold_compare,
    .mclk_in, .mclk_out, .mclk_oe, .logic_clock_out_pin, .logic_clock_oe, .adc_mux_sel,
    .adc_atten_div3, .adc_start, .adc_done, .adc_code, .link(link.dev));
  mct_host u_mct_host (.ref_clk, .rstn, .clk_mode, .export_lclk, .window_req, .thr_ordered,
    .filter_req, .cmd_go, .cmd_chan, .cmd_atten, .cmd_busy, .res_valid, .res_code, .res_mv,
    .status_a, .status_b, .tmr_run, .tmr_step, .tmr_expired, .link(link.host));
  mct_link_properties u_mct_link_properties (.ref_clk, .rstn, .mon_a(link.mon_a),
    .mon_b(link.mon_b), .logic_tick(link.logic_tick), .window_mode(link.window_mode),
    .sw_int_clk(link.sw_int_clk), .meas_req(link.meas_req), .meas_done(link.meas_done),
    .res_high(link.res_high), .res_low(link.res_low), .tmr_start(link.tmr_start),
    .tmr_done(link.tmr_done));
  // ==================================================================
  // Clocks, converter stand-in and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    ext_mclk = 1'b0;
    #7;
    forever #62.5 ext_mclk = ~ext_mclk;
  end
  // Code is scrambled off its valid cycle so a late sample fails
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    adc_code <= ~cur_code;
    if (adc_start) begin
      adc_wait <= cur_dly;
      seen_sel <= adc_mux_sel;
      seen_att <= adc_atten_div3;
      started  <= 1'b1;
    end else if (adc_wait != 3'h0) begin
      adc_wait <= adc_wait - 3'h1;
      adc_done <= (adc_wait == 3'h1);
      adc_code <= (adc_wait == 3'h1) ? cur_code : ~cur_code;
    end
  end
  // The whole run needs about 30k cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ==================================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A second request while busy must be ignored
  task automatic meas(input mct_row_t r);
    int w;
    cur_code = r.code;
    cur_dly = r.dly;
    @(posedge ref_clk);
    started <= 1'b0;
    cmd_go <= 1'b1;
    cmd_chan <= r.chan;
    cmd_atten <= r.atten;
    @(posedge ref_clk);
    cmd_chan <= r.chan ^ 4'h1;
    cmd_atten <= ~r.atten;
    @(posedge ref_clk);
    cmd_go <= 1'b0;
    for (w = 0; w < 60 && res_valid !== 1'b1; w++) cyc(1);
    chk(w < 60 && res_code === r.exp && res_mv === {r.exp, 1'b0}, "result");
    chk({link.res_high, link.res_low} === r.exp, "readout split");
    chk(started === (r.chan < 4'hC), "conversion start");
    if (r.chan < 4'hC) chk(seen_sel === r.chan && seen_att === r.atten, "mux");
  endtask
  task automatic gap_of(input logic pick, output int n);
    int   k, first;
    logic p, c;
    p = 1'b1;
    first = -1;
    n = 0;
    for (k = 0; k < 400 && n == 0; k++) begin
      cyc(1);
      c = pick ? logic_clock_out_pin : mclk_out;
      if (c === 1'b1 && p === 1'b0) begin
        if (first >= 0) n = k - first;
        else first = k;
      end
      p = c;
    end
  endtask
  // ==================================================================
  // Main sequence
  initial begin
    int k, n, tc;
    logic [3:0]  got;
    logic [11:0] ex;
    {rstn, cmd_go, cmd_atten, export_lclk, adc_done, started, seen_att} = '0;
    {upper_threshold_compare, lower_threshold_compare, window_req, thr_ordered} = '0;
    {filter_req, cmd_chan, tmr_run, tmr_step, adc_code, cur_code, adc_wait, seen_sel} = '0;
    {n_mismatch, cmp_count, cycles} = '0;
    cur_dly = 3'h1;
    clk_mode = mct_pkg::MCT_STANDALONE;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(2);
    chk(mclk_oe === 1'b0 && logic_clock_oe === 1'b0, "standalone pins");
    for (k = 0; k < 6; k++) meas(rows[k]);
    @(posedge ref_clk);
    window_req <= 12'hF0F;
    thr_ordered <= 12'hFF0;
    for (k = 0; k < 3; k++) begin
      upper_threshold_compare <= {12{k == 2}};
      lower_threshold_compare <= {12{k != 0}};
      cyc(1000);
      ex = (12'hF00 & lower_threshold_compare & ~upper_threshold_compare);
      ex = ex | (12'h0FF & upper_threshold_compare);
      chk(status_a === ex && link.mon_a === ex, "primary output");
      chk(status_b === lower_threshold_compare, "secondary output");
      @(posedge ref_clk);
    end
    filter_req <= 12'h001;
    {upper_threshold_compare, lower_threshold_compare} <= '0;
    cyc(500);
    chk(status_b === 12'hFFF, "short delay too early");
    cyc(400);
    chk(status_b === 12'h001, "short and long delay");
    cyc(2000);
    chk(status_b === 12'h000, "long delay");
    @(posedge ref_clk);
    lower_threshold_compare <= 12'hFFF;
    cyc(300);
    @(posedge ref_clk);
    lower_threshold_compare <= 12'h000;
    cyc(1000);
    chk(status_b === 12'h000, "glitch passed");
    while (link.logic_tick !== 1'b1) cyc(1);
    @(posedge ref_clk);
    for (k = 0; k < 4; k++) tmr_step[k] <= 7'(stp[k]);
    tmr_run <= 4'hF;
    tc = 0;
    got = 4'h0;
    for (n = 0; n < 25000 && got !== 4'hF; n++) begin
      cyc(1);
      for (k = 0; k < 4; k++) begin
        ex = 12'(8 + ((stp[k] * stp[k] * mct_pkg::TMR_CURVE_MUL) >> mct_pkg::TMR_CURVE_SHIFT));
        if (link.tmr_done[k] === 1'b1 && !got[k]) begin
          got[k] = 1'b1;
          chk(tc == ex, "timeout count");
        end
      end
      if (link.logic_tick === 1'b1) tc++;
    end
    cyc(1);
    chk(got === 4'hF && tmr_expired === 4'hF, "timers expired");
    @(posedge ref_clk);
    tmr_run <= 4'h0;
    cyc(4);
    chk(tmr_expired === 4'h0, "timers cleared");
    @(posedge ref_clk);
    clk_mode <= mct_pkg::MCT_MASTER;
    export_lclk <= 1'b1;
    cyc(4);
    chk(mclk_oe === 1'b1 && logic_clock_oe === 1'b1, "master pins");
    gap_of(1'b0, n);
    chk(n == 5, "master clock rate");
    gap_of(1'b1, n);
    chk(n == 160, "logic clock rate");
    @(posedge ref_clk);
    clk_mode <= mct_pkg::MCT_SLAVE;
    cyc(4);
    chk(mclk_oe === 1'b0, "slave pin");
    gap_of(1'b1, n);
    gap_of(1'b1, n);
    chk(n >= 150 && n <= 170, "slave logic clock");
    @(posedge ref_clk);
    lower_threshold_compare <= 12'hFFF;
    cyc(1000);
    @(posedge ref_clk);
    rstn <= 1'b0;
    cyc(3);
    chk(link.mon_b === 12'h000 && mclk_oe === 1'b0, "values in reset");
    @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(3000);
    chk(status_b === 12'hFFF, "monitor after reset");
    complete_run();
  end
endmodule
